// file: bench/board_pins.sv
`timescale 1ns/10ps
module board_pins (
    input wire logic clk_i,
    input wire logic [23:0] oe_i,
    input wire logic [23:0] drive_i,
    input wire logic [23:0] ext_en_i,
    input wire logic [23:0] ext_val_i,
    input wire logic [2:0] pull_i,
    output logic [23:0] pad_o
);
    // Undriven line without pull-high flickers so a float never reads as a fixed level
    logic flicker = 1'b0;
    always @(posedge clk_i)
        flicker <= ~flicker;
    always_comb
        for (int i = 0; i < 24; i++)
            pad_o[i] = oe_i[i] ? drive_i[i] : ext_en_i[i] ? ext_val_i[i]
                     : pull_i[i / 8] ? 1'b1 : flicker;
endmodule

// file: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr = 1'b0, rd = 1'b0, div_en = 1'b0, div_sel = 1'b0, tone_en = 1'b0;
    logic tone = 1'b0, pwm_en = 1'b0, ie0 = 1'b0, ie1 = 1'b0, clr = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic [7:0] rdata, tbase, v, e, dir, lat, ext;
    logic [3:0] wave = 4'h0;
    logic [2:0] pull_opt = 3'h0;
    logic [2:0] pull;
    logic [23:0] ext_en = 24'hFFFFFF, ext_val = 24'h000000;
    logic [23:0] pad, drive, oe;
    logic irq0, irq1, wake;
    logic [7:0] base [3] = '{8'h12, 8'h14, 8'h18};
    int err_count = 0;
    int n_checks = 0;
    int t;
    always #10 clk_i = ~clk_i;
    gpio_timer_pins dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wr_i(wr), .rd_i(rd),
        .wdata_i(wdata), .rdata_o(rdata), .divider_enable_i(div_en),
        .divider_select_i(div_sel), .tone_enable_i(tone_en), .tone_out_i(tone),
        .pwm_enable_i(pwm_en), .pwm_wave_i(wave), .pull_high_option_i(pull_opt),
        .timer0_int_enable_i(ie0), .timer1_int_enable_i(ie1), .timer0_flag_clear_i(clr),
        .timer1_flag_clear_i(clr), .port_a_pad_i(pad[7:0]), .port_a_pad_o(drive[7:0]),
        .port_a_oe_o(oe[7:0]), .port_b_pad_i(pad[15:8]), .port_b_pad_o(drive[15:8]),
        .port_b_oe_o(oe[15:8]), .port_d_pad_i(pad[23:16]), .port_d_pad_o(drive[23:16]),
        .port_d_oe_o(oe[23:16]), .pull_high_o(pull), .pwm_time_base_o(tbase),
        .timer0_irq_o(irq0), .timer1_irq_o(irq1), .wake_o(wake));
    board_pins board (.clk_i(clk_i), .oe_i(oe), .drive_i(drive), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pull_i(pull), .pad_o(pad));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Early edges may straddle a reconfiguration, so only the third gap is judged
    task automatic gap(input int exp);
        int n;
        for (int k = 0; k < 3; k++)
        begin
            v[0] = drive[3];
            n = 0;
            while (drive[3] === v[0] && n < 600)
            begin
                @(posedge clk_i);
                #1 n++;
            end
            if (n == 600)
            begin
                err_count++;
                final_report();
            end
        end
        chk(8'(n), 8'(exp));
    endtask
    task automatic steady();
        // Pad lags the divider, so an overflow at the stop edge shows up late
        repeat (2) @(posedge clk_i);
        #1 v[0] = drive[3];
        repeat (40) @(posedge clk_i);
        #1 chk({7'h0, drive[3]}, {7'h0, v[0]});
    endtask
    initial
    begin
        v = 8'($urandom(32'hC61941FF));
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1 chk(oe[7:0] | oe[15:8] | oe[23:16], 8'h00);
        rd_reg(8'h13, v);
        chk(v, 8'hFF);
        rd_reg(8'h16, v);
        chk(v, 8'h00);
        for (int p = 0; p < 3; p++)
        begin
            dir = 8'($urandom);
            lat = 8'($urandom);
            ext = 8'($urandom);
            @(posedge clk_i);
            ext_val[p*8 +: 8] <= ext;
            wr_reg(base[p], lat);
            wr_reg(base[p] + 8'h01, dir);
            repeat (5) @(posedge clk_i);
            rd_reg(base[p], v);
            chk(v, (dir & ext) | (~dir & lat));
            chk(oe[p*8 +: 8], ~dir);
            chk(drive[p*8 +: 8] & ~dir, lat & ~dir);
        end
        // Input bits read from pads land in the latch on write-back
        rd_reg(8'h12, v);
        wr_reg(8'h12, v ^ 8'h81);
        wr_reg(8'h13, 8'h00);
        rd_reg(8'h12, lat);
        chk(lat, v ^ 8'h81);
        wr_reg(8'h13, 8'hFF);
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_i);
            ext_val[i] <= ~ext_val[i];
            t = 0;
            repeat (8)
            begin
                @(posedge clk_i);
                #1 t = t | int'(wake === 1'b1);
            end
            chk(8'(t), 8'h01);
        end
        @(posedge clk_i);
        ext_en[15:8] <= 8'h00;
        pull_opt <= 3'h2;
        wr_reg(8'h15, 8'hFF);
        repeat (5) @(posedge clk_i);
        rd_reg(8'h14, v);
        chk(v, 8'hFF);
        chk({5'h0, pull}, 8'h02);
        #1 v = tbase;
        @(posedge clk_i);
        #1 chk(tbase, v + 8'h01);
        wr_reg(8'h13, 8'h00);
        wr_reg(8'h12, 8'h08);
        @(posedge clk_i);
        div_en <= 1'b1;
        wr_reg(8'h0D, 8'hFE);
        rd_reg(8'h0D, v);
        chk(v, 8'hFE);
        for (int p = 0; p < 4; p++)
        begin
            wr_reg(8'h0E, 8'h10 | 8'(p));
            gap(2 << p);
        end
        chk({7'h0, irq0}, 8'h00);
        @(posedge clk_i);
        ie0 <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 chk({7'h0, irq0}, 8'h01);
        wr_reg(8'h0D, 8'hFC);
        gap(32);
        wr_reg(8'h0E, 8'h03);
        steady();
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk({7'h0, irq0}, 8'h00);
        wr_reg(8'h12, 8'h00);
        repeat (2) @(posedge clk_i);
        #1 chk({7'h0, drive[3]}, 8'h00);
        wr_reg(8'h12, 8'h08);
        @(posedge clk_i);
        div_sel <= 1'b1;
        wr_reg(8'h0E, 8'h10);
        steady();
        wr_reg(8'h10, 8'hFE);
        wr_reg(8'h0F, 8'hFF);
        wr_reg(8'h11, 8'h10);
        gap(8);
        chk({7'h0, irq1}, 8'h00);
        @(posedge clk_i);
        div_en <= 1'b0;
        tone_en <= 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clk_i);
            tone <= 1'($urandom);
            lat = (k == 4) ? 8'h02 : 8'(k);
            wr_reg(8'h13, (k == 4) ? 8'h01 : 8'h00);
            wr_reg(8'h12, lat);
            repeat (2) @(posedge clk_i);
            e = (k == 4) ? {6'h0, ~tone, 1'b0} : {6'h0, lat[0] & ~tone, lat[0] & tone};
            #1 chk({6'h0, drive[1:0] & oe[1:0]}, e);
        end
        @(posedge clk_i);
        pwm_en <= 1'b1;
        wr_reg(8'h19, 8'hF0);
        for (int k = 0; k < 4; k++)
        begin
            lat = 8'($urandom);
            @(posedge clk_i);
            wave <= 4'($urandom);
            wr_reg(8'h18, lat);
            repeat (2) @(posedge clk_i);
            #1 chk({4'h0, drive[19:16]}, {4'h0, wave & lat[3:0]});
        end
        final_report();
    end
endmodule

// file: logic/divider_timer.sv
`timescale 1ns/10ps
module divider_timer #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic preload_wr_i,
    input wire logic [W-1:0] preload_i,
    input wire logic read_block_i,
    output logic [W-1:0] count_o,
    output logic overflow_o,
    output logic div_o
);
    typedef struct packed {
        logic [W-1:0] count;
        logic [W-1:0] preload;
        logic overflow;
        logic div;
    } timer_state_t;

    timer_state_t s;
    timer_state_t next_s;
    logic step;

    assign step = run_i && tick_i && !read_block_i;

    always_comb
    begin
        next_s = s;
        next_s.overflow = 1'b0;
        if (preload_wr_i)
        begin
            next_s.preload = preload_i;
            if (!run_i)
            begin
                next_s.count = preload_i;
            end
        end
        if (step)
        begin
            if (&s.count)
            begin
                // Newest preload wins on overflow
                next_s.count = preload_wr_i ? preload_i : s.preload;
                next_s.overflow = 1'b1;
                next_s.div = ~s.div;
            end
            else
            begin
                next_s.count = s.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign count_o = s.count;
    assign overflow_o = s.overflow;
    assign div_o = s.div;

    // ****************************************
    // Checks
    // ****************************************
    property p_stop_load;
        @(posedge clk_i) disable iff (!rst_n_i)
        (preload_wr_i && !run_i) |=> (s.count == $past(preload_i));
    endproperty
    a_stop_load: assert property (p_stop_load) else $error("stopped write missed counter");

    property p_run_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (preload_wr_i && run_i && !step) |=> (s.count == $past(s.count));
    endproperty
    a_run_write: assert property (p_run_write) else $error("running write disturbed count");

    property p_read_block;
        @(posedge clk_i) disable iff (!rst_n_i)
        (read_block_i && !(preload_wr_i && !run_i)) |=> $stable(s.count);
    endproperty
    a_read_block: assert property (p_read_block) else $error("count moved during read");

    property p_reload;
        @(posedge clk_i) disable iff (!rst_n_i)
        (step && (&s.count) && !preload_wr_i) |=> (overflow_o && s.count == $past(s.preload));
    endproperty
    a_reload: assert property (p_reload) else $error("overflow did not reload");

    property p_div_toggle;
        @(posedge clk_i) disable iff (!rst_n_i)
        overflow_o |-> (div_o != $past(div_o));
    endproperty
    a_div_toggle: assert property (p_div_toggle) else $error("divider did not toggle");
endmodule

// file: logic/gpio_timer_pins.sv
`timescale 1ns/10ps
module gpio_timer_pins (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic divider_enable_i,
    input wire logic divider_select_i,
    input wire logic tone_enable_i,
    input wire logic tone_out_i,
    input wire logic pwm_enable_i,
    input wire logic [3:0] pwm_wave_i,
    input wire logic [2:0] pull_high_option_i,
    input wire logic timer0_int_enable_i,
    input wire logic timer1_int_enable_i,
    input wire logic timer0_flag_clear_i,
    input wire logic timer1_flag_clear_i,
    input wire logic [7:0] port_a_pad_i,
    output logic [7:0] port_a_pad_o,
    output logic [7:0] port_a_oe_o,
    input wire logic [7:0] port_b_pad_i,
    output logic [7:0] port_b_pad_o,
    output logic [7:0] port_b_oe_o,
    input wire logic [7:0] port_d_pad_i,
    output logic [7:0] port_d_pad_o,
    output logic [7:0] port_d_oe_o,
    output logic [2:0] pull_high_o,
    output logic [7:0] pwm_time_base_o,
    output logic timer0_irq_o,
    output logic timer1_irq_o,
    output logic wake_o
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] timer0_control;
        logic [7:0] timer1_control;
        logic [7:0] low_buf;
        logic [7:0] prescale;
        logic timer0_flag;
        logic timer1_flag;
        logic timer0_irq;
        logic timer1_irq;
        logic wake;
        logic [2:0] pull_high;
    } top_state_t;

    top_state_t s;
    top_state_t next_s;

    logic [7:0] t0_count;
    logic [15:0] t1_count;
    logic t0_ovf;
    logic t1_ovf;
    logic t0_div;
    logic t1_div;
    logic [7:0] a_read;
    logic [7:0] b_read;
    logic [7:0] d_read;
    logic [7:0] a_latch;
    logic [7:0] d_latch;
    logic [7:0] a_dir;
    logic a_change;
    logic [7:0] a_alt_en;
    logic [7:0] a_alt_val;
    logic [7:0] d_alt_en;
    logic [7:0] d_alt_val;
    logic [7:0] t0_mask;
    logic t0_tick;
    logic t1_tick;
    logic t0_read;
    logic t1_read;
    logic divider_sel;
    logic tone_gate_bar;

    // ****************************************
    // Prescaler and timers
    // ****************************************
    assign t0_mask = 8'hFF >> (4'h8 - {1'b0,
        s.timer0_control[pin_port_pkg::PRESCALE_MSB:pin_port_pkg::PRESCALE_LSB]});
    assign t0_tick = (s.prescale & t0_mask) == t0_mask;
    assign t1_tick = s.prescale[1:0] == pin_port_pkg::TIMER1_TICK_MASK;
    assign t0_read = rd_i && addr_i == pin_port_pkg::ADDR_TIMER0_COUNT;
    assign t1_read = rd_i && addr_i == pin_port_pkg::ADDR_TIMER1_HIGH;

    divider_timer #(.W(8)) u_timer0 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(t0_tick),
        .run_i(s.timer0_control[pin_port_pkg::RUN_BIT]),
        .preload_wr_i(wr_i && addr_i == pin_port_pkg::ADDR_TIMER0_COUNT),
        .preload_i(wdata_i),
        .read_block_i(t0_read),
        .count_o(t0_count),
        .overflow_o(t0_ovf),
        .div_o(t0_div)
    );

    // Upper byte write commits the buffered low byte as one 16-bit preload
    divider_timer #(.W(16)) u_timer1 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(t1_tick),
        .run_i(s.timer1_control[pin_port_pkg::RUN_BIT]),
        .preload_wr_i(wr_i && addr_i == pin_port_pkg::ADDR_TIMER1_HIGH),
        .preload_i({wdata_i, s.low_buf}),
        .read_block_i(t1_read),
        .count_o(t1_count),
        .overflow_o(t1_ovf),
        .div_o(t1_div)
    );

    // ****************************************
    // Ports and shared pin functions
    // ****************************************
    assign divider_sel = divider_select_i ? t1_div : t0_div;
    // Both tone lines driving: line 0 latch gates the pair
    assign tone_gate_bar = (!a_dir[pin_port_pkg::TONE_LINE]
        && !a_dir[pin_port_pkg::TONE_BAR_LINE])
        ? a_latch[pin_port_pkg::TONE_LINE] : a_latch[pin_port_pkg::TONE_BAR_LINE];

    always_comb
    begin
        a_alt_en = 8'h00;
        a_alt_val = 8'h00;
        d_alt_en = 8'h00;
        d_alt_val = 8'h00;
        a_alt_en[pin_port_pkg::DIVIDER_LINE] = divider_enable_i;
        a_alt_val[pin_port_pkg::DIVIDER_LINE] =
            a_latch[pin_port_pkg::DIVIDER_LINE] & divider_sel;
        a_alt_en[pin_port_pkg::TONE_LINE] = tone_enable_i;
        a_alt_en[pin_port_pkg::TONE_BAR_LINE] = tone_enable_i;
        a_alt_val[pin_port_pkg::TONE_LINE] =
            a_latch[pin_port_pkg::TONE_LINE] & tone_out_i;
        a_alt_val[pin_port_pkg::TONE_BAR_LINE] = tone_gate_bar & ~tone_out_i;
        for (int i = 0; i < pin_port_pkg::PWM_LINES; i++)
        begin
            d_alt_en[i] = pwm_enable_i;
            d_alt_val[i] = d_latch[i] & pwm_wave_i[i];
        end
    end

    io_line_port #(.W(8)) u_port_a (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_data_i(wr_i && addr_i == pin_port_pkg::ADDR_PORT_A_DATA),
        .wr_dir_i(wr_i && addr_i == pin_port_pkg::ADDR_PORT_A_DIRECTION),
        .wdata_i(wdata_i),
        .alt_en_i(a_alt_en),
        .alt_val_i(a_alt_val),
        .pad_i(port_a_pad_i),
        .pad_o(port_a_pad_o),
        .oe_o(port_a_oe_o),
        .read_o(a_read),
        .latch_o(a_latch),
        .dir_o(a_dir),
        .change_o(a_change)
    );

    io_line_port #(.W(8)) u_port_b (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_data_i(wr_i && addr_i == pin_port_pkg::ADDR_PORT_B_DATA),
        .wr_dir_i(wr_i && addr_i == pin_port_pkg::ADDR_PORT_B_DIRECTION),
        .wdata_i(wdata_i),
        .alt_en_i(8'h00),
        .alt_val_i(8'h00),
        .pad_i(port_b_pad_i),
        .pad_o(port_b_pad_o),
        .oe_o(port_b_oe_o),
        .read_o(b_read),
        .latch_o(),
        .dir_o(),
        .change_o()
    );

    io_line_port #(.W(8)) u_port_d (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_data_i(wr_i && addr_i == pin_port_pkg::ADDR_PORT_D_DATA),
        .wr_dir_i(wr_i && addr_i == pin_port_pkg::ADDR_PORT_D_DIRECTION),
        .wdata_i(wdata_i),
        .alt_en_i(d_alt_en),
        .alt_val_i(d_alt_val),
        .pad_i(port_d_pad_i),
        .pad_o(port_d_pad_o),
        .oe_o(port_d_oe_o),
        .read_o(d_read),
        .latch_o(d_latch),
        .dir_o(),
        .change_o()
    );

    // ****************************************
    // Register access and flags
    // ****************************************
    always_comb
    begin
        next_s = s;
        next_s.prescale = s.prescale + 8'h01;
        next_s.pull_high = pull_high_option_i;
        next_s.wake = a_change;
        if (wr_i)
        begin
            case (addr_i)
                pin_port_pkg::ADDR_TIMER0_CONTROL:
                    next_s.timer0_control = wdata_i & pin_port_pkg::TIMER0_CONTROL_MASK;
                pin_port_pkg::ADDR_TIMER1_CONTROL:
                    next_s.timer1_control = wdata_i & pin_port_pkg::TIMER1_CONTROL_MASK;
                pin_port_pkg::ADDR_TIMER1_LOW:
                    next_s.low_buf = wdata_i;
                default:
                    next_s.low_buf = s.low_buf;
            endcase
        end
        if (rd_i)
        begin
            case (addr_i)
                pin_port_pkg::ADDR_TIMER0_COUNT: next_s.rdata = t0_count;
                pin_port_pkg::ADDR_TIMER0_CONTROL: next_s.rdata = s.timer0_control;
                pin_port_pkg::ADDR_TIMER1_HIGH:
                begin
                    next_s.rdata = t1_count[15:8];
                    next_s.low_buf = t1_count[7:0];
                end
                pin_port_pkg::ADDR_TIMER1_LOW: next_s.rdata = s.low_buf;
                pin_port_pkg::ADDR_TIMER1_CONTROL: next_s.rdata = s.timer1_control;
                pin_port_pkg::ADDR_PORT_A_DATA: next_s.rdata = a_read;
                pin_port_pkg::ADDR_PORT_A_DIRECTION: next_s.rdata = a_dir;
                pin_port_pkg::ADDR_PORT_B_DATA: next_s.rdata = b_read;
                pin_port_pkg::ADDR_PORT_D_DATA: next_s.rdata = d_read;
                default: next_s.rdata = pin_port_pkg::READ_UNMAPPED;
            endcase
        end
        // Set beats clear so an overflow in the clear cycle is kept
        if (timer0_flag_clear_i)
        begin
            next_s.timer0_flag = 1'b0;
        end
        if (t0_ovf)
        begin
            next_s.timer0_flag = 1'b1;
        end
        if (timer1_flag_clear_i)
        begin
            next_s.timer1_flag = 1'b0;
        end
        if (t1_ovf)
        begin
            next_s.timer1_flag = 1'b1;
        end
        next_s.timer0_irq = next_s.timer0_flag & timer0_int_enable_i;
        next_s.timer1_irq = next_s.timer1_flag & timer1_int_enable_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign rdata_o = s.rdata;
    assign pull_high_o = s.pull_high;
    assign pwm_time_base_o = s.prescale;
    assign timer0_irq_o = s.timer0_irq;
    assign timer1_irq_o = s.timer1_irq;
    assign wake_o = s.wake;

    // ****************************************
    // Checks
    // ****************************************
    property p_irq_gate;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!timer0_int_enable_i && !timer1_int_enable_i) |=> (!timer0_irq_o && !timer1_irq_o);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("disabled timer raised request");

    property p_divider_low;
        @(posedge clk_i) disable iff (!rst_n_i)
        (divider_enable_i && !a_latch[3] && !a_dir[3]) |=> (port_a_pad_o[3] == 1'b0);
    endproperty
    a_divider_low: assert property (p_divider_low) else $error("divider pad not forced low");

    property p_tone_pair;
        @(posedge clk_i) disable iff (!rst_n_i)
        (tone_enable_i && a_dir[1:0] == 2'h0 && !a_latch[0]) |=> (port_a_pad_o[1:0] == 2'h0);
    endproperty
    a_tone_pair: assert property (p_tone_pair) else $error("tone pair not gated by line 0");
endmodule

// file: logic/io_line_port.sv
`timescale 1ns/10ps
module io_line_port #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_data_i,
    input wire logic wr_dir_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic [W-1:0] alt_en_i,
    input wire logic [W-1:0] alt_val_i,
    input wire logic [W-1:0] pad_i,
    output logic [W-1:0] pad_o,
    output logic [W-1:0] oe_o,
    output logic [W-1:0] read_o,
    output logic [W-1:0] latch_o,
    output logic [W-1:0] dir_o,
    output logic change_o
);
    typedef struct packed {
        logic [W-1:0] latch;
        logic [W-1:0] dir;
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
        logic [W-1:0] pad_out;
        logic [W-1:0] oe;
        logic change;
    } port_state_t;

    port_state_t s;
    port_state_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.s1 = pad_i;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < W; i++)
        begin
            if (s.s2[i] == s.s3[i])
            begin
                next_s.stable[i] = s.s2[i];
            end
        end
        next_s.change = |((next_s.stable ^ s.stable) & s.dir);
        if (wr_data_i)
        begin
            next_s.latch = wdata_i;
        end
        if (wr_dir_i)
        begin
            next_s.dir = wdata_i;
        end
        // Push-pull only: enable follows direction, no open-drain case
        next_s.oe = ~next_s.dir;
        for (int i = 0; i < W; i++)
        begin
            next_s.pad_out[i] = alt_en_i[i] ? alt_val_i[i] : next_s.latch[i];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s <= '0;
            s.latch <= pin_port_pkg::LATCH_RESET[W-1:0];
            s.dir <= pin_port_pkg::DIRECTION_RESET[W-1:0];
        end
        else
        begin
            s <= next_s;
        end
    end

    // Pad read uses the synchronised, filtered stable value, so software sees a pad change four clocks late
    assign read_o = (s.dir & s.stable) | (~s.dir & s.latch);
    assign pad_o = s.pad_out;
    assign oe_o = s.oe;
    assign latch_o = s.latch;
    assign dir_o = s.dir;
    assign change_o = s.change;

    // ****************************************
    // Checks
    // ****************************************
    property p_latch_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        !wr_data_i |=> $stable(s.latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed without write");

    property p_dir_oe;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_dir_i |=> (oe_o == ~$past(wdata_i));
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("enable not tied to direction");
endmodule

// file: logic/pin_port_pkg.sv
package pin_port_pkg;
    // ****************************************
    // Register addresses in data memory
    // ****************************************
    localparam logic [7:0] ADDR_TIMER0_COUNT = 8'h0D;
    localparam logic [7:0] ADDR_TIMER0_CONTROL = 8'h0E;
    localparam logic [7:0] ADDR_TIMER1_HIGH = 8'h0F;
    localparam logic [7:0] ADDR_TIMER1_LOW = 8'h10;
    localparam logic [7:0] ADDR_TIMER1_CONTROL = 8'h11;
    localparam logic [7:0] ADDR_PORT_A_DATA = 8'h12;
    localparam logic [7:0] ADDR_PORT_A_DIRECTION = 8'h13;
    localparam logic [7:0] ADDR_PORT_B_DATA = 8'h14;
    localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'h15;
    localparam logic [7:0] ADDR_PORT_D_DATA = 8'h18;
    localparam logic [7:0] ADDR_PORT_D_DIRECTION = 8'h19;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PRESCALE_LSB = 0;
    localparam int PRESCALE_MSB = 2;
    localparam int RUN_BIT = 4;
    localparam int DIVIDER_LINE = 3;
    localparam int TONE_LINE = 0;
    localparam int TONE_BAR_LINE = 1;
    localparam int PWM_LINES = 4;

    // ****************************************
    // Reset values and masks
    // ****************************************
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'hFF;
    localparam logic [7:0] TIMER0_CONTROL_MASK = 8'hDF;
    localparam logic [7:0] TIMER1_CONTROL_MASK = 8'hF8;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [1:0] TIMER1_TICK_MASK = 2'h3;
endpackage
